// [logic/cis_charger_interrupt_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_charger_interrupt_status_regs #(
    parameter logic [27:0] WD_GRACE_SHORT = 28'(cis_pkg::WD_GRACE_SHORT_CYC),
    parameter logic [27:0] WD_GRACE_LONG = 28'(cis_pkg::WD_GRACE_LONG_CYC)
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire cis_pkg::cis_reg_req_t reg_req_in,
    input wire cis_pkg::cis_analog_status_t status_in,
    input wire cis_pkg::cis_events_t events_in,
    input wire logic [cis_pkg::DATA_W-1:0] status_two_in,
    input wire logic watchdog_long_period_in,
    input wire logic watchdog_kick_in,
    output logic [cis_pkg::DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    output logic irq_out,
    output logic watchdog_expired_out
);
    logic [cis_pkg::NUM_SRC-1:0] irq_enable_ff, nxt_irq_enable;
    logic [cis_pkg::NUM_SRC-1:0] irq_active_ff, nxt_irq_active;
    cis_pkg::cis_analog_status_t status_ff, nxt_status;
    logic charge_done_latch_ff, nxt_charge_done_latch;
    logic [cis_pkg::DATA_W-1:0] rd_data_ff, nxt_rd_data;
    logic rd_valid_ff, nxt_rd_valid;
    logic irq_ff, nxt_irq;
    logic wd_run_ff, nxt_wd_run;
    logic [cis_pkg::WD_CNT_W-1:0] wd_cnt_ff, nxt_wd_cnt;
    logic wd_expired_ff, nxt_wd_expired;

    logic [cis_pkg::NUM_SRC-1:0] src_event;
    logic [cis_pkg::NUM_SRC-1:0] src_set;
    logic [cis_pkg::NUM_SRC-1:0] src_clr;
    logic [cis_pkg::DATA_W-1:0] status_one_word;
    logic rd_active;
    logic wr_enable;
    logic input_level_change;
    logic charge_mode_change;
    logic die_temp_rise;
    logic charge_start;
    logic charge_end;
    logic [cis_pkg::WD_CNT_W-1:0] wd_load;

    // Status sampled once so events are edges of a registered copy
    always_comb begin
        nxt_status = status_in;
    end

    // Level inputs become events by comparing against last cycle's copy
    assign input_level_change =
        (status_in.input_good_flag != status_ff.input_good_flag) ||
        (status_in.input_overvoltage_flag != status_ff.input_overvoltage_flag);
    assign charge_mode_change = (status_in.charger_state != status_ff.charger_state);
    assign die_temp_rise = status_in.die_temp_limited_flag && !status_ff.die_temp_limited_flag;

    always_comb begin
        src_event = '0;
        src_event[cis_pkg::SRC_INPUT_LEVEL] = input_level_change;
        src_event[cis_pkg::SRC_CHARGE_MODE] = charge_mode_change;
        src_event[cis_pkg::SRC_BATTERY_LEVEL] = events_in.battery_level_event;
        src_event[cis_pkg::SRC_THERMISTOR] = events_in.thermistor_event;
        src_event[cis_pkg::SRC_OVERTEMP] = events_in.overtemp_event;
        src_event[cis_pkg::SRC_WATCHDOG] = events_in.watchdog_alarm;
        src_event[cis_pkg::SRC_THERMAL_LIMIT] = die_temp_rise;
    end

    assign rd_active = reg_req_in.rd && (reg_req_in.addr == cis_pkg::ADDR_IRQ_ACTIVE);

    // Read of the active register clears it; a same-cycle event survives
    for (genvar i = 0; i < cis_pkg::NUM_SRC; i++) begin : g_src
        assign src_set[i] = src_event[i] && irq_enable_ff[i];
        assign src_clr[i] = rd_active;
        always_comb begin
            nxt_irq_active[i] = src_set[i] || (irq_active_ff[i] && !src_clr[i]);
        end
    end

    // Charge done latch: only a new charge start clears it
    assign charge_start = (status_in.charger_state == cis_pkg::CHG_TRICKLE) ||
                          (status_in.charger_state == cis_pkg::CHG_FAST_CC);
    assign charge_end = (status_in.charger_state == cis_pkg::CHG_COMPLETE);

    always_comb begin
        nxt_charge_done_latch = charge_done_latch_ff;
        if (charge_start) begin
            nxt_charge_done_latch = 1'b0;
        end
        // Set wins so a completion seen in the same cycle is never lost
        if (charge_end) begin
            nxt_charge_done_latch = 1'b1;
        end
    end

    always_comb begin
        status_one_word = {status_ff.input_overvoltage_flag,
                           status_ff.input_good_flag,
                           status_ff.input_current_limited_flag,
                           status_ff.die_temp_limited_flag,
                           charge_done_latch_ff,
                           status_ff.charger_state};
    end

    // Register port: only the enable register takes writes
    assign wr_enable = reg_req_in.wr && (reg_req_in.addr == cis_pkg::ADDR_IRQ_ENABLE);

    always_comb begin
        nxt_irq_enable = irq_enable_ff;
        if (wr_enable) begin
            nxt_irq_enable = reg_req_in.wdata[cis_pkg::NUM_SRC-1:0];
        end
    end

    // Zero when idle, so a stale byte never looks like an answer
    always_comb begin
        nxt_rd_valid = reg_req_in.rd;
        nxt_rd_data = cis_pkg::READ_ZERO;
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                cis_pkg::ADDR_IRQ_ENABLE: nxt_rd_data = {1'b0, irq_enable_ff};
                cis_pkg::ADDR_IRQ_ACTIVE: nxt_rd_data = {1'b0, irq_active_ff};
                cis_pkg::ADDR_STATUS_ONE: nxt_rd_data = status_one_word;
                cis_pkg::ADDR_STATUS_TWO: nxt_rd_data = status_two_in;
                default: nxt_rd_data = cis_pkg::READ_ZERO;
            endcase
        end
    end

    // New active bits feed the output so it rises with the flag
    always_comb begin
        nxt_irq = |(nxt_irq_active & irq_enable_ff);
    end

    // Period is taken at the alarm; changing it mid-countdown has no effect
    assign wd_load = watchdog_long_period_in ? WD_GRACE_LONG : WD_GRACE_SHORT;

    // Watchdog grace: expiry a fixed time after the alarm unless kicked
    always_comb begin
        nxt_wd_run = wd_run_ff;
        nxt_wd_cnt = wd_cnt_ff;
        nxt_wd_expired = 1'b0;
        if (watchdog_kick_in) begin
            nxt_wd_run = 1'b0;
            nxt_wd_cnt = cis_pkg::WD_CNT_ZERO;
        end else if (events_in.watchdog_alarm && !wd_run_ff) begin
            nxt_wd_run = 1'b1;
            nxt_wd_cnt = wd_load;
        end else if (wd_run_ff) begin
            if (wd_cnt_ff <= cis_pkg::WD_CNT_ONE) begin
                nxt_wd_run = 1'b0;
                nxt_wd_cnt = cis_pkg::WD_CNT_ZERO;
                nxt_wd_expired = 1'b1;
            end else begin
                nxt_wd_cnt = wd_cnt_ff - cis_pkg::WD_CNT_ONE;
            end
        end
    end

    // Register port state
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_enable_ff <= cis_pkg::IRQ_ENABLE_RESET;
            rd_data_ff <= cis_pkg::READ_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            irq_enable_ff <= nxt_irq_enable;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // Interrupt state
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_active_ff <= cis_pkg::IRQ_ACTIVE_RESET;
            irq_ff <= 1'b0;
        end else begin
            irq_active_ff <= nxt_irq_active;
            irq_ff <= nxt_irq;
        end
    end

    // Status copy and done latch
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            status_ff <= '0;
            charge_done_latch_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            charge_done_latch_ff <= nxt_charge_done_latch;
        end
    end

    // Watchdog grace state
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wd_run_ff <= 1'b0;
            wd_cnt_ff <= cis_pkg::WD_CNT_ZERO;
            wd_expired_ff <= 1'b0;
        end else begin
            wd_run_ff <= nxt_wd_run;
            wd_cnt_ff <= nxt_wd_cnt;
            wd_expired_ff <= nxt_wd_expired;
        end
    end

    assign rd_data_out = rd_data_ff;
    assign rd_valid_out = rd_valid_ff;
    assign irq_out = irq_ff;
    assign watchdog_expired_out = wd_expired_ff;
endmodule
`default_nettype wire

// [shared/cis_pkg.sv]
package cis_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_SRC = 7;

    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ACTIVE = 8'h0A;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_ONE = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_TWO = 8'h0C;

    localparam logic [NUM_SRC-1:0] IRQ_ENABLE_RESET = 7'h00;
    localparam logic [NUM_SRC-1:0] IRQ_ACTIVE_RESET = 7'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // Interrupt source bit positions
    localparam int SRC_INPUT_LEVEL = 0;
    localparam int SRC_CHARGE_MODE = 1;
    localparam int SRC_BATTERY_LEVEL = 2;
    localparam int SRC_THERMISTOR = 3;
    localparam int SRC_OVERTEMP = 4;
    localparam int SRC_WATCHDOG = 5;
    localparam int SRC_THERMAL_LIMIT = 6;

    // Charger state codes
    localparam logic [2:0] CHG_OFF = 3'h0;
    localparam logic [2:0] CHG_TRICKLE = 3'h1;
    localparam logic [2:0] CHG_FAST_CC = 3'h2;
    localparam logic [2:0] CHG_FAST_CV = 3'h3;
    localparam logic [2:0] CHG_COMPLETE = 3'h4;
    localparam logic [2:0] CHG_REGULATOR = 3'h5;
    localparam logic [2:0] CHG_TIMER_EXPIRED = 3'h6;
    localparam logic [2:0] CHG_BATT_DETECT = 3'h7;

    // Watchdog expiry grace after the alarm
    localparam longint CLK_HZ = 50_000_000;
    localparam longint WD_GRACE_SHORT_S = 2;
    localparam longint WD_GRACE_LONG_S = 4;
    localparam longint WD_GRACE_SHORT_CYC = WD_GRACE_SHORT_S * CLK_HZ;
    localparam longint WD_GRACE_LONG_CYC = WD_GRACE_LONG_S * CLK_HZ;
    localparam int WD_CNT_W = 28;
    localparam logic [WD_CNT_W-1:0] WD_CNT_ZERO = 28'h0000000;
    localparam logic [WD_CNT_W-1:0] WD_CNT_ONE = 28'h0000001;

    typedef struct packed {
        logic input_overvoltage_flag;
        logic input_good_flag;
        logic input_current_limited_flag;
        logic die_temp_limited_flag;
        logic [2:0] charger_state;
    } cis_analog_status_t;

    typedef struct packed {
        logic overtemp_event;
        logic thermistor_event;
        logic battery_level_event;
        logic watchdog_alarm;
    } cis_events_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cis_reg_req_t;
endpackage

// [testbench/cis_irq_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_irq_asserts #(
    parameter logic [27:0] WD_GRACE_SHORT = 28'h000000A,
    parameter logic [27:0] WD_GRACE_LONG = 28'h0000014
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire cis_pkg::cis_reg_req_t reg_req_in,
    input wire cis_pkg::cis_analog_status_t status_in,
    input wire cis_pkg::cis_events_t events_in,
    input wire logic [cis_pkg::DATA_W-1:0] status_two_in,
    input wire logic watchdog_long_period_in,
    input wire logic watchdog_kick_in,
    input wire logic [cis_pkg::DATA_W-1:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic irq_out,
    input wire logic watchdog_expired_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire logic rd = reg_req_in.rd;
    wire logic [7:0] ad = reg_req_in.addr;
    wire logic rd_st = rd && ad == 8'h0B;
    wire logic en_off = reg_req_in.wr && ad == 8'h09 && reg_req_in.wdata == 8'h00;
    property p_rd_valid; rd |=> rd_valid_out; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_idle; !rd |=> !rd_valid_out && rd_data_out == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_bit7; rd && (ad == 8'h09 || ad == 8'h0A) |=> !rd_data_out[7]; endproperty
    a_bit7: assert property (p_bit7) else $error("unused bit seven set");
    property p_unmap; rd && ad > 8'h0C |=> rd_data_out == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    property p_flags; rd_st |=> rd_data_out[7:4] == $past(status_in[6:3], 2); endproperty
    a_flags: assert property (p_flags) else $error("status flags wrong");
    property p_state; rd_st |=> rd_data_out[2:0] == $past(status_in[2:0], 2); endproperty
    a_state: assert property (p_state) else $error("charger state wrong");
    property p_en_off; en_off ##1 !reg_req_in.wr |=> !irq_out; endproperty
    a_en_off: assert property (p_en_off) else $error("irq with all disabled");
    property p_wd; watchdog_expired_out |=> !watchdog_expired_out; endproperty
    a_wd: assert property (p_wd) else $error("expiry not a pulse");
    c_irq: cover property (irq_out);
    c_wd: cover property (watchdog_expired_out);
    c_rd: cover property (rd_valid_out && rd_data_out != 8'h00);
endmodule
`default_nettype wire

// [testbench/cis_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_host_model (
    input wire logic ref_clk_in,
    input wire logic [cis_pkg::DATA_W-1:0] rd_data_in,
    input wire logic rd_valid_in,
    output var cis_pkg::cis_reg_req_t req_out
);
    initial req_out = '0;
    // Strobe spans exactly one rising edge; data taken after that edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic v);
        @(negedge ref_clk_in);
        req_out = '{w, !w, a, d};
        @(negedge ref_clk_in);
        q = rd_data_in;
        v = rd_valid_in;
        // Released lines show inverted values so stale data cannot pass
        req_out = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    cis_pkg::cis_reg_req_t reg_req_in;
    cis_pkg::cis_analog_status_t status_in = '0;
    cis_pkg::cis_events_t events_in = '0;
    logic [7:0] status_two_in = 8'h5A;
    logic watchdog_long_period_in = 1'b0;
    logic watchdog_kick_in = 1'b0;
    logic [7:0] rd_data_out, q;
    logic rd_valid_out, irq_out, watchdog_expired_out, v;
    int error_cnt = 0;
    int check_count = 0;
    int i;
    cis_charger_interrupt_status_regs #(.WD_GRACE_SHORT(28'hA), .WD_GRACE_LONG(28'h14)) dut_u (
        .ref_clk_in, .rst_in, .reg_req_in, .status_in, .events_in, .status_two_in,
        .watchdog_long_period_in, .watchdog_kick_in, .rd_data_out, .rd_valid_out,
        .irq_out, .watchdog_expired_out);
    cis_host_model host_u (.ref_clk_in, .rd_data_in(rd_data_out),
        .rd_valid_in(rd_valid_out), .req_out(reg_req_in));
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.xfer(1'b0, a, 8'h00, q, v);
        check({7'h00, v}, 8'h01);
        check(q, exp);
    endtask
    task automatic pulse(input logic [3:0] p);
        @(negedge ref_clk_in);
        events_in = p;
        @(negedge ref_clk_in);
        events_in = '0;
        @(negedge ref_clk_in);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge ref_clk_in);
        rst_in = 1'b0;
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h0A, 8'h00);
        host_u.xfer(1'b1, 8'h09, 8'hFF, q, v);
        rd_chk(8'h09, 8'h7F);
        for (i = 0; i < 3; i++) begin
            pulse(4'h2 << i);
            check({7'h00, irq_out}, 8'h01);
            rd_chk(8'h0A, 8'h04 << i);
            @(negedge ref_clk_in);
            check({7'h00, irq_out}, 8'h00);
        end
        for (int l = 0; l < 2; l++) begin
            watchdog_long_period_in = l[0];
            events_in = 4'h1;
            i = 0;
            while (watchdog_expired_out !== 1'b1 && i < 40) begin
                @(negedge ref_clk_in);
                events_in = '0;
                i++;
            end
            // Grace count plus the rising edge that loads the counter at the alarm
            check(8'(i), 8'(11 + 10 * l));
            if (i == 40) give_verdict();
            rd_chk(8'h0A, 8'h20);
        end
        // A kick during the grace must cancel the expiry
        events_in = 4'h1;
        @(negedge ref_clk_in);
        events_in = '0;
        watchdog_kick_in = 1'b1;
        @(negedge ref_clk_in);
        watchdog_kick_in = 1'b0;
        v = 1'b0;
        repeat (30) begin
            @(negedge ref_clk_in);
            v = v | watchdog_expired_out;
        end
        check({7'h00, v}, 8'h00);
        rd_chk(8'h0A, 8'h20);
        status_in = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h3};
        rd_chk(8'h0B, 8'hF3);
        rd_chk(8'h0A, 8'h43);
        for (i = 0; i < 8; i++) begin
            status_in.charger_state = i[2:0];
            rd_chk(8'h0B, {4'hF, i >= 4, i[2:0]});
        end
        status_in.charger_state = 3'h3;
        rd_chk(8'h0B, 8'hFB);
        status_in = '{1'b0, 1'b1, 1'b0, 1'b1, 3'h6};
        rd_chk(8'h0B, 8'h5E);
        status_in.charger_state = 3'h2;
        rd_chk(8'h0B, 8'h52);
        rd_chk(8'h0C, 8'h5A);
        rd_chk(8'h20, 8'h00);
        host_u.xfer(1'b1, 8'h09, 8'h00, q, v);
        pulse(4'hE);
        check({7'h00, irq_out}, 8'h00);
        rd_chk(8'h0A, 8'h03);
        give_verdict();
    end
endmodule
bind cis_charger_interrupt_status_regs cis_irq_asserts #(.WD_GRACE_SHORT(WD_GRACE_SHORT),
    .WD_GRACE_LONG(WD_GRACE_LONG)) chk_u (.ref_clk_in, .rst_in, .reg_req_in, .status_in,
    .events_in, .status_two_in, .watchdog_long_period_in, .watchdog_kick_in, .rd_data_out,
    .rd_valid_out, .irq_out, .watchdog_expired_out);
`default_nettype wire
